// >>> bench/formatter_monitor.sv
// port-level assertions for the readout frame formatter
`timescale 1ns/100ps
`include "frame_map.svh"
module formatter_monitor (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rec_valid,
   input wire logic rec_ready,
   input wire logic rec_is_header,
   input wire logic [15:0] pixel_group_addr,
   input wire logic reg_taken,
   input wire logic lane_valid,
   input wire logic [1:0] lane_sync,
   input wire logic [63:0] lane_data
);
   logic [1:0] mode_reg;
   logic dump_reg;
   logic [5:0] age_reg;
   // a frame already in flight may still carry the old mode
   wire logic settled = age_reg == 6'h3F;
   wire logic proto = settled && mode_reg == 2'h0 && !dump_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= 2'h0;
         dump_reg <= 1'h0;
         age_reg <= 6'h3F;
      end else if (psel && penable && pwrite && paddr == `CTRL_OFS) begin
         mode_reg <= pwdata[1:0];
         dump_reg <= pwdata[`CTRL_DUMP_BIT];
         age_reg <= 6'h00;
      end else if (!settled) begin
         age_reg <= age_reg + 6'h01;
      end
   end
////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence quiet_frame;
      (!lane_valid) [*8] ##1 (!lane_valid) [*7];
   endsequence
   sequence ctrl_frame_out;
      lane_valid && lane_sync == `SYNC_CTRL;
   endsequence
   apb_ready_a: assert property (pready == (psel && penable))
      else $error("pready not tied to access phase");
   apb_refuse_a: assert property (psel && penable |->
      pslverr == (paddr > `DUMP_SYNC_OFS || paddr[1:0] != 2'h0))
      else $error("bad pslverr");
   frame_pulse_a: assert property (lane_valid |=> quiet_frame)
      else $error("frames closer than 16 cycles");
   reg_out_a: assert property (reg_taken && proto |->
      ##[1:3] ctrl_frame_out) else $error("register frame not sent");
   sync_legal_a: assert property (lane_valid && proto |->
      lane_sync inside {`SYNC_DATA, `SYNC_CTRL}) else $error("bad sync");
   clock_pattern_a: assert property (
      lane_valid && settled && mode_reg == 2'h1 |->
      {lane_sync, lane_data} == {33{2'h2}}) else $error("bad clock");
   dump_quiet_a: assert property (settled && dump_reg |-> !lane_valid)
      else $error("lane active in slow readout");
   prefix_refuse_a: assert property (rec_valid && !rec_is_header &&
      pixel_group_addr[15:9] == `HEADER_PREFIX |-> !rec_ready)
      else $error("hit with header prefix taken");
endmodule : formatter_monitor

bind readout_frame_formatter formatter_monitor mon (.mclk, .rst_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .rec_valid,
   .rec_ready, .rec_is_header, .pixel_group_addr, .reg_taken, .lane_valid,
   .lane_sync, .lane_data);

// >>> bench/frame_receiver.sv
// receiving end of the lane: descrambles every frame it sees
`timescale 1ns/100ps
`include "frame_map.svh"
module frame_receiver (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic lane_valid,
   input wire logic [1:0] lane_sync,
   input wire logic [63:0] lane_data,
   output logic rx_seen,
   output logic [1:0] rx_sync,
   output logic [63:0] rx_plain,
   output logic [65:0] rx_raw
);
   logic [57:0] hist_reg;
   logic [63:0] p;
   // self-synchronous: a missed frame spoils only the next 58 bits
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hist_reg = `SCRAMBLE_SEED;
         rx_seen <= 1'h0;
      end else begin
         rx_seen <= lane_valid;
         if (lane_valid) begin
            for (int i = 0; i < 64; i++) begin
               p[i] = lane_data[i] ^ hist_reg[38] ^ hist_reg[57];
               hist_reg = {hist_reg[56:0], lane_data[i]};
            end
            rx_sync <= lane_sync;
            rx_plain <= p;
            rx_raw <= {lane_sync, lane_data};
         end
      end
   end
endmodule : frame_receiver

// >>> bench/test_readout_frame_formatter.sv
// self-checking bench for the readout frame formatter
`timescale 1ns/100ps
`include "frame_map.svh"
module test_readout_frame_formatter;
   logic mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, rec_valid = 1'h0, rec_is_header = 1'h0;
   logic error_event = 1'h0, warning_event = 1'h0;
   logic trigger_queue_full = 1'h0, cmd_locked = 1'h0;
   logic [7:0] paddr = '0, reg_block_code = 8'h80;
   logic [31:0] pwdata = '0, prdata, r, lo, hi;
   logic [4:0] trigger_id = '0, trigger_tag = '0;
   logic [14:0] bunch_crossing_count = '0;
   logic [15:0] pixel_group_addr = '0, pixel_charges = '0;
   logic [9:0] reg_addr_a = '0, reg_addr_b = '0;
   logic [15:0] reg_value_a = '0, reg_value_b = '0;
   logic pready, pslverr, irq, rec_ready, reg_taken, lane_valid;
   logic rx_seen, e, ok, er_s, wn_s, found;
   logic [1:0] lane_sync, rx_sync;
   logic [63:0] lane_data, rx_plain;
   logic [65:0] rx_raw;
   logic [5:0] rn;
   logic [63:0] dq[$], rq[$];
   int n_errors = 0, n_tests = 0, seed = 32'h50CD, phase = 0, a, k;
   int n_since = -99, ival = 2, n_idle = 0;
   readout_frame_formatter DUT (.mclk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .rec_valid,
      .rec_ready, .rec_is_header, .trigger_id, .trigger_tag,
      .bunch_crossing_count, .pixel_group_addr, .pixel_charges,
      .reg_block_code, .reg_addr_a, .reg_value_a, .reg_addr_b, .reg_value_b,
      .reg_taken, .error_event, .warning_event, .trigger_queue_full,
      .cmd_locked, .lane_valid, .lane_sync, .lane_data);
   frame_receiver daq (.mclk, .rst_n, .lane_valid, .lane_sync, .lane_data,
      .rx_seen, .rx_sync, .rx_plain, .rx_raw);
   initial forever #5 mclk = ~mclk;
////////////////////////////////////////
   task chk_word(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         n_errors++;
         $display("MISMATCH %0t word %h expected %h", $time, g, x);
      end
   endtask : chk_word
   task chk_frame(input logic [65:0] g, input logic [65:0] x);
      n_tests++;
      if (g !== x) begin
         n_errors++;
         $display("MISMATCH %0t frame %h expected %h", $time, g, x);
      end
   endtask : chk_frame
   task chk_flag(input logic g, input logic x);
      n_tests++;
      if (g !== x) begin
         n_errors++;
         $display("MISMATCH %0t flag %b expected %b", $time, g, x);
      end
   endtask : chk_flag
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do @(posedge mclk); while (!pready);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask : apb
   task send_pair(input logic [1:0] hd);
      logic [31:0] b[2];
      for (int i = 0; i < 2; i++) begin
         b[i] = $random(seed);
         b[i][31] = 1'h1;
         if (hd[i]) b[i][31:25] = `HEADER_PREFIX;
         rec_valid <= 1'h1;
         rec_is_header <= hd[i];
         {trigger_id, trigger_tag, bunch_crossing_count} <= b[i][24:0];
         {pixel_group_addr, pixel_charges} <= b[i];
         do @(posedge mclk); while (!rec_ready);
      end
      rec_valid <= 1'h0;
      dq.push_back({b[0], b[1]});
      @(posedge mclk);
   endtask : send_pair
   task print_verdict;
      $display("errors %0d comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
////////////////////////////////////////
   // new register frame content and status sources right after each register frame build
   always @(posedge mclk) begin
      if (rst_n && reg_taken) begin
         if (phase == 0) rq.push_back({reg_block_code, reg_addr_a,
            reg_value_a, reg_addr_b, reg_value_b, !cmd_locked ? `ST_NOLOCK :
            trigger_queue_full ? `ST_QFULL : {2'h0, wn_s, er_s}});
         rn = 6'($random(seed));
         {wn_s, er_s} = rn[1:0];
         error_event <= er_s;
         warning_event <= wn_s;
         cmd_locked <= |rn[3:2];
         trigger_queue_full <= &rn[5:4];
         {reg_block_code, reg_addr_a, reg_value_a, reg_addr_b, reg_value_b}
            <= 60'({$random(seed), $random(seed)}) | 60'h800000000000000;
      end else begin
         error_event <= 1'h0;
         warning_event <= 1'h0;
      end
   end
   always @(posedge mclk) begin
      if (rx_seen && phase == 0) begin
         if (rx_sync == `SYNC_DATA) begin
            n_since++;
            chk_frame({rx_sync, rx_plain}, {`SYNC_DATA, dq.size() ?
               dq.pop_front() : 64'hX});
         end else if (rx_plain[63:56] == `IDLE_CODE) begin
            n_since++;
            n_idle++;
            chk_frame({rx_sync, rx_plain}, {`SYNC_CTRL, `IDLE_CODE, 56'h0});
         end else begin
            chk_frame({rx_sync, rx_plain}, {`SYNC_CTRL, rq.size() ?
               rq.pop_front() : 64'hX});
            if (n_since >= 0) chk_word(n_since, ival);
            n_since = 0;
         end
      end
      if (rx_seen && phase > 1) begin
         k = phase == 2 ? 7 : 31;
         a = phase == 2 ? 6 : 28;
         ok = |rx_raw;
         for (int j = 0; j + k < 66; j++)
            ok &= rx_raw[j] == (rx_raw[j+a] ^ rx_raw[j+k]);
         chk_flag(ok, 1'h1);
      end
   end
   initial begin
      #200000;
      n_errors++;
      print_verdict;
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'h1;
      @(posedge mclk);
      apb(1'h0, `CTRL_OFS, '0);
      chk_word(r, `CTRL_RESET);
      apb(1'h0, `INTERVAL_OFS, '0);
      chk_word(r, 32'(`INTERVAL_RESET));
      apb(1'h0, 8'h40, '0);
      chk_word(r, '0);
      chk_flag(e, 1'h1);
      apb(1'h1, `INTERVAL_OFS, 32'h2);
      n_since = -99;
      rec_valid <= 1'h1;
      pixel_group_addr <= {`HEADER_PREFIX, 9'h155};
      repeat (3) @(posedge mclk);
      chk_flag(rec_ready, 1'h0);
      rec_valid <= 1'h0;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) send_pair(2'(i));
      do @(posedge mclk); while (!reg_taken);
      repeat (4) @(posedge mclk);
      apb(1'h0, `IRQ_STAT_OFS, '0);
      chk_flag(r[`IRQ_REG_SENT], 1'h1);
      chk_flag(irq, 1'h0);
      apb(1'h1, `IRQ_MASK_OFS, 32'h1);
      chk_flag(irq, 1'h1);
      apb(1'h1, `IRQ_STAT_OFS, 32'hF);
      chk_flag(irq, 1'h0);
      apb(1'h0, `IRQ_STAT_OFS, '0);
      chk_flag(r[`IRQ_REG_SENT], 1'h0);
      for (int i = 0; i < 24; i++) begin
         send_pair(2'(i));
         repeat (32) @(posedge mclk);
      end
      chk_flag(n_idle != 0, 1'h1);
      phase = 1;
      apb(1'h1, `CTRL_OFS, 32'h10);
      apb(1'h1, `INTERVAL_OFS, 32'hFF);
      // empty the dump so the data frame does not find it full
      apb(1'h0, `DUMP_HI_OFS, '0);
      send_pair(2'h1);
      found = 1'h0;
      for (int i = 0; i < 60 && !found; i++) begin
         apb(1'h0, `STATUS_OFS, '0);
         if (r[8]) begin
            apb(1'h0, `DUMP_LO_OFS, '0);
            lo = r;
            apb(1'h0, `DUMP_HI_OFS, '0);
            found = {r, lo} === dq[$];
         end
      end
      chk_flag(found, 1'h1);
      apb(1'h1, `CTRL_OFS, 32'h1);
      repeat (100) @(posedge mclk);
      for (int m = 2; m < 4; m++) begin
         apb(1'h1, `CTRL_OFS, m);
         repeat (40) @(posedge mclk);
         phase = m;
         repeat (160) @(posedge mclk);
         phase = 1;
      end
      print_verdict;
   end
endmodule : test_readout_frame_formatter

// >>> common/frame_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef FRAME_MAP_SVH
`define FRAME_MAP_SVH

`define CTRL_OFS 8'h00
`define INTERVAL_OFS 8'h04
`define STATUS_OFS 8'h08
`define IRQ_STAT_OFS 8'h0C
`define IRQ_MASK_OFS 8'h10
`define DUMP_LO_OFS 8'h14
`define DUMP_HI_OFS 8'h18
`define DUMP_SYNC_OFS 8'h1C

`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_DUMP_BIT 4
`define CTRL_RESET 32'h0000_0000
`define INTERVAL_RESET 8'h30

`define IRQ_W 4
`define IRQ_REG_SENT 0
`define IRQ_QFULL 1
`define IRQ_LOCK_LOST 2
`define IRQ_DUMP_READY 3

`define SYNC_DATA 2'h1
`define SYNC_CTRL 2'h2
`define IDLE_CODE 8'h78
`define HEADER_PREFIX 7'h01

`define ST_READY 4'h0
`define ST_ERROR 4'h1
`define ST_WARN 4'h2
`define ST_BOTH 4'h3
`define ST_QFULL 4'h5
`define ST_NOLOCK 4'h6

`define FRAME_CYCLES 8'h10
`define PRBS7_SEED 7'h7F
`define PRBS31_SEED 31'h7FFF_FFFF
`define SCRAMBLE_SEED 58'h3FF_FFFF_FFFF_FFFF

`endif

// >>> common/frame_pkg.sv
// types shared by the frame formatter and its helpers
package frame_pkg;
   typedef enum logic [1:0] {
      MODE_PROTOCOL,
      MODE_CLOCK,
      MODE_PRBS7,
      MODE_PRBS31
   } test_mode_t;

   typedef enum {
      FRAME_IDLE,
      FRAME_DATA,
      FRAME_REG
   } frame_kind_t;
endpackage : frame_pkg

// >>> rtl/frame_scrambler.sv
// self-synchronous x^58+x^39+1 payload scrambler
`timescale 1ns/100ps
`include "frame_map.svh"
module frame_scrambler (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic step,
   input wire logic [63:0] plain,
   output logic [63:0] scrambled
);
   logic [57:0] state_reg;
   logic [57:0] state_next;
   logic [63:0] bits;

   always_comb begin
      state_next = state_reg;
      bits = '0;
      for (int i = 0; i < 64; i++) begin
         bits[i] = plain[i] ^ state_next[38] ^ state_next[57];
         state_next = {state_next[56:0], bits[i]};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= `SCRAMBLE_SEED;
         scrambled <= '0;
      end else if (step) begin
         state_reg <= state_next;
         scrambled <= bits;
      end
   end
endmodule : frame_scrambler

// >>> rtl/readout_frame_formatter.sv
// output frame builder: data, idle and register frames, test patterns
//
// Behaviour
// - register frames carry status 1 for error, 2 for warning, 3 both, 0 ready.
// - status 5 is sent while the trigger queue is full and the command input is locked; the controller then stops triggering.
// - status 6 is sent while the command input is unlocked; codes 7 to 15 are never sent.
// - a hit data frame holds two records, each a row and a four-column group.
// - event header records go out as data frames with sync 01, not command frames.
// - a header record is prefix 0000001, 5-bit trigger id, 5-bit tag, 15-bit crossing count.
// - any other first seven bits mean hit data: 16-bit address and four 4-bit charges.
// - record layouts apply before scrambling; the payload is scrambled on output.
// - from reset, without lock, idle and register frames still flow as a heartbeat.
// - a configuration mode replaces the protocol by clock, PRBS-7 or PRBS-31 patterns.
// - software can read the unencoded payload instead of the lanes.
// - a register frame is block code, two 10-bit address plus 16-bit value pairs, status.
// - a register frame goes out only after every programmed count of other frames.
// - sync 01 marks data frames, sync 10 marks register and idle frames.
`timescale 1ns/100ps
`include "frame_map.svh"
module readout_frame_formatter (
   input wire logic mclk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // record stream
   input wire logic rec_valid,
   output logic rec_ready,
   input wire logic rec_is_header,
   input wire logic [4:0] trigger_id,
   input wire logic [4:0] trigger_tag,
   input wire logic [14:0] bunch_crossing_count,
   input wire logic [15:0] pixel_group_addr,
   input wire logic [15:0] pixel_charges,
   // register frame content
   input wire logic [7:0] reg_block_code,
   input wire logic [9:0] reg_addr_a,
   input wire logic [15:0] reg_value_a,
   input wire logic [9:0] reg_addr_b,
   input wire logic [15:0] reg_value_b,
   output logic reg_taken,
   // status sources
   input wire logic error_event,
   input wire logic warning_event,
   input wire logic trigger_queue_full,
   input wire logic cmd_locked,
   // lane output
   output logic lane_valid,
   output logic [1:0] lane_sync,
   output logic [63:0] lane_data
);

   ////////////////////////////////////////////////////////////////////////
   // registers and frame timing state

   logic [31:0] ctrl_reg;
   logic [7:0] interval_reg;
   logic [`IRQ_W-1:0] irq_stat_reg;
   logic [`IRQ_W-1:0] irq_mask_reg;
   logic [63:0] dump_reg;
   logic [1:0] dump_sync_reg;
   logic dump_valid_reg;
   logic error_reg;
   logic warning_reg;
   logic qfull_d_reg;
   logic lock_d_reg;
   logic [7:0] tick_cnt_reg;
   logic [7:0] frame_cnt_reg;
   logic [31:0] slot_reg [2];
   logic [1:0] slot_full_reg;
   logic [63:0] plain_reg;
   logic [1:0] sync_reg;
   logic pending_reg;
   logic [1:0] mode;
   logic frame_tick;
   logic emit_tick;
   logic [63:0] scrambled;
   logic [65:0] pattern;
   logic [31:0] record;
   logic [3:0] status_code;
   logic [`IRQ_W-1:0] irq_events;
   logic wr_access;
   logic rd_setup;
   logic rd_access;
   logic addr_ok;
   frame_pkg::frame_kind_t kind;

   assign mode = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];

   ////////////////////////////////////////////////////////////////////////
   // apb slave: prdata is loaded at setup, so pready is high in access

   assign wr_access = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_access = psel && penable && !pwrite;

   always_comb begin
      unique case (paddr)
         `CTRL_OFS, `INTERVAL_OFS, `STATUS_OFS, `IRQ_STAT_OFS,
         `IRQ_MASK_OFS, `DUMP_LO_OFS, `DUMP_HI_OFS,
         `DUMP_SYNC_OFS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign pready = psel && penable;
   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
      end else if (rd_setup) begin
         unique case (paddr)
            `CTRL_OFS: prdata <= ctrl_reg;
            `INTERVAL_OFS: prdata <= {24'h00_0000, interval_reg};
            `STATUS_OFS: prdata <= {23'h00_0000, dump_valid_reg,
               cmd_locked, trigger_queue_full, warning_reg, error_reg,
               status_code};
            `IRQ_STAT_OFS: prdata <= {28'h000_0000, irq_stat_reg};
            `IRQ_MASK_OFS: prdata <= {28'h000_0000, irq_mask_reg};
            `DUMP_LO_OFS: prdata <= dump_reg[31:0];
            `DUMP_HI_OFS: prdata <= dump_reg[63:32];
            `DUMP_SYNC_OFS: prdata <= {30'h0000_0000, dump_sync_reg};
            default: prdata <= '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `CTRL_RESET;
         interval_reg <= `INTERVAL_RESET;
         irq_mask_reg <= '0;
      end else if (wr_access) begin
         if (paddr == `CTRL_OFS) begin
            ctrl_reg <= {27'h000_0000, pwdata[`CTRL_DUMP_BIT], 2'h0,
               pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]};
         end
         if (paddr == `INTERVAL_OFS) begin
            interval_reg <= pwdata[7:0];
         end
         if (paddr == `IRQ_MASK_OFS) begin
            irq_mask_reg <= pwdata[`IRQ_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupts: sticky status, write one to clear, set wins

   assign irq_events[`IRQ_REG_SENT] = emit_tick && kind == frame_pkg::FRAME_REG;
   assign irq_events[`IRQ_QFULL] = trigger_queue_full && !qfull_d_reg;
   assign irq_events[`IRQ_LOCK_LOST] = !cmd_locked && lock_d_reg;
   assign irq_events[`IRQ_DUMP_READY] = emit_tick && ctrl_reg[`CTRL_DUMP_BIT]
      && mode == 2'h0;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= '0;
         qfull_d_reg <= 1'b0;
         lock_d_reg <= 1'b0;
      end else begin
         qfull_d_reg <= trigger_queue_full;
         lock_d_reg <= cmd_locked;
         irq_stat_reg <= (irq_stat_reg & ~((wr_access
            && paddr == `IRQ_STAT_OFS) ? pwdata[`IRQ_W-1:0] : '0))
            | irq_events;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // status code, sticky error and warning

   always_comb begin
      if (!cmd_locked) begin
         status_code = `ST_NOLOCK;
      end else if (trigger_queue_full) begin
         status_code = `ST_QFULL;
      end else begin
         status_code = {2'h0, warning_reg, error_reg};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         error_reg <= 1'b0;
         warning_reg <= 1'b0;
      end else begin
         if (error_event) begin
            error_reg <= 1'b1;
         end else if (emit_tick && kind == frame_pkg::FRAME_REG) begin
            error_reg <= 1'b0;
         end
         if (warning_event) begin
            warning_reg <= 1'b1;
         end else if (emit_tick && kind == frame_pkg::FRAME_REG) begin
            warning_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame divider and register frame slotting

   assign frame_tick = tick_cnt_reg == `FRAME_CYCLES - 8'h01;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= '0;
      end else if (frame_tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
   end

   // protocol frames are built even in test mode, so the slot count keeps
   // its phase when the pattern is switched off again
   assign emit_tick = frame_tick;

   always_comb begin
      if (frame_cnt_reg >= interval_reg) begin
         kind = frame_pkg::FRAME_REG;
      end else if (&slot_full_reg) begin
         kind = frame_pkg::FRAME_DATA;
      end else begin
         kind = frame_pkg::FRAME_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt_reg <= '0;
      end else if (emit_tick) begin
         if (kind == frame_pkg::FRAME_REG) begin
            frame_cnt_reg <= '0;
         end else begin
            frame_cnt_reg <= frame_cnt_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // record slots: two records pair into one data frame, first in high half

   always_comb begin
      if (rec_is_header) begin
         record = {`HEADER_PREFIX, trigger_id, trigger_tag,
            bunch_crossing_count};
      end else begin
         record = {pixel_group_addr, pixel_charges};
      end
   end

   // a hit address equal to the header prefix would be misread downstream
   assign rec_ready = !(&slot_full_reg) && (rec_is_header
      || pixel_group_addr[15:9] != `HEADER_PREFIX);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slot_full_reg <= '0;
         slot_reg[0] <= '0;
         slot_reg[1] <= '0;
      end else if (emit_tick && kind == frame_pkg::FRAME_DATA) begin
         slot_full_reg <= '0;
      end else if (rec_valid && rec_ready) begin
         if (!slot_full_reg[0]) begin
            slot_reg[0] <= record;
            slot_full_reg[0] <= 1'b1;
         end else begin
            slot_reg[1] <= record;
            slot_full_reg[1] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame assembly before scrambling

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         plain_reg <= '0;
         sync_reg <= `SYNC_CTRL;
         pending_reg <= 1'b0;
         reg_taken <= 1'b0;
      end else begin
         pending_reg <= emit_tick;
         reg_taken <= emit_tick && kind == frame_pkg::FRAME_REG;
         if (emit_tick) begin
            unique case (kind)
               frame_pkg::FRAME_DATA: begin
                  sync_reg <= `SYNC_DATA;
                  plain_reg <= {slot_reg[0], slot_reg[1]};
               end
               frame_pkg::FRAME_REG: begin
                  sync_reg <= `SYNC_CTRL;
                  plain_reg <= {reg_block_code, reg_addr_a, reg_value_a,
                     reg_addr_b, reg_value_b, status_code};
               end
               frame_pkg::FRAME_IDLE: begin
                  sync_reg <= `SYNC_CTRL;
                  plain_reg <= {`IDLE_CODE, 56'h00_0000_0000_0000};
               end
            endcase
         end
      end
   end

   frame_scrambler u_scrambler (
      .mclk(mclk),
      .rst_n(rst_n),
      .step(pending_reg),
      .plain(plain_reg),
      .scrambled(scrambled)
   );

   test_pattern_gen u_pattern (
      .mclk(mclk),
      .rst_n(rst_n),
      .step(pending_reg),
      .mode(mode),
      .pattern(pattern)
   );

   ////////////////////////////////////////////////////////////////////////
   // lane output and unencoded dump for slow readout

   logic out_sync_reg;
   logic [1:0] sync_d_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_sync_reg <= 1'b0;
         sync_d_reg <= `SYNC_CTRL;
      end else begin
         out_sync_reg <= pending_reg;
         if (pending_reg) begin
            sync_d_reg <= sync_reg;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lane_valid <= 1'b0;
      end else begin
         // lanes stay silent while slow readout owns the data
         lane_valid <= out_sync_reg && !ctrl_reg[`CTRL_DUMP_BIT];
      end
   end

   always_comb begin
      if (mode != 2'h0) begin
         lane_sync = pattern[65:64];
         lane_data = pattern[63:0];
      end else begin
         lane_sync = sync_d_reg;
         lane_data = scrambled;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dump_reg <= '0;
         dump_sync_reg <= '0;
         dump_valid_reg <= 1'b0;
      end else begin
         if (pending_reg && ctrl_reg[`CTRL_DUMP_BIT] && !dump_valid_reg) begin
            dump_valid_reg <= 1'b1;
         end else if (rd_access && paddr == `DUMP_HI_OFS) begin
            dump_valid_reg <= 1'b0;
         end
         // taken before scrambling; a frame that finds the dump full is lost
         if (pending_reg && ctrl_reg[`CTRL_DUMP_BIT] && !dump_valid_reg) begin
            dump_reg <= plain_reg;
            dump_sync_reg <= sync_reg;
         end
      end
   end

endmodule : readout_frame_formatter

// >>> rtl/test_pattern_gen.sv
// fixed test sequences, 66 bits per frame step
`timescale 1ns/100ps
`include "frame_map.svh"
module test_pattern_gen (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic step,
   input wire logic [1:0] mode,
   output logic [65:0] pattern
);
   logic [6:0] p7_reg;
   logic [30:0] p31_reg;
   logic [6:0] p7_next;
   logic [30:0] p31_next;
   logic [65:0] p7_bits;
   logic [65:0] p31_bits;

   always_comb begin
      p7_next = p7_reg;
      p31_next = p31_reg;
      p7_bits = '0;
      p31_bits = '0;
      for (int i = 65; i >= 0; i--) begin
         p7_next = {p7_next[5:0], p7_next[6] ^ p7_next[5]};
         p31_next = {p31_next[29:0], p31_next[30] ^ p31_next[27]};
         p7_bits[i] = p7_next[0];
         p31_bits[i] = p31_next[0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         p7_reg <= `PRBS7_SEED;
         p31_reg <= `PRBS31_SEED;
         pattern <= '0;
      end else if (step) begin
         p7_reg <= p7_next;
         p31_reg <= p31_next;
         unique case (frame_pkg::test_mode_t'(mode))
            frame_pkg::MODE_CLOCK: pattern <= {33{2'h2}};
            frame_pkg::MODE_PRBS7: pattern <= p7_bits;
            frame_pkg::MODE_PRBS31: pattern <= p31_bits;
            frame_pkg::MODE_PROTOCOL: pattern <= '0;
         endcase
      end
   end
endmodule : test_pattern_gen
